// >>> rtl/tpio_consts.vh
// Contract
// - Port A latch readable, writable, kept across reset.
// - Direction bit one enables output buffer.
// - Reset clears port A direction bits.
// - Port A output bits read back latch.
// - Port A input bits read sampled pin.
// - Latch writes always land, any direction.
// - Input bit write changes latch, not read.
// - Port A pullup needs enable and input.
// - Output direction turns pullup off at once.
// - Key enable makes port A pin interrupt input.
// - Converter channel forces port B pin analog.
// - Unselected port B pins stay digital I/O.
// - Port B output bits read back latch.
// - Port B input bits read pin, no pullup.
// - Port B latches kept across reset.
// - Reset clears port B direction bits.
// - Port C: seven pins, latches kept on reset.
// - Reset clears port C direction bits.
// - Port C reads latch or pin by direction.
`ifndef TPIO_CONSTS_VH
`define TPIO_CONSTS_VH

// Bus widths.
`define TPIO_ADDR_W      12
`define TPIO_DATA_W      32
`define TPIO_PORT_W      8
`define TPIO_PORTC_W     7
`define TPIO_IDX_W       4
`define TPIO_ADCH_W      5

// Register indices; the byte address is four times the index.
`define TPIO_IDX_A_DATA  4'h0
`define TPIO_IDX_B_DATA  4'h1
`define TPIO_IDX_C_DATA  4'h2
`define TPIO_IDX_A_DIR   4'h4
`define TPIO_IDX_B_DIR   4'h5
`define TPIO_IDX_C_DIR   4'h6
`define TPIO_IDX_A_PUE   4'hd
`define TPIO_IDX_C_PUE   4'he

// Address field positions.
`define TPIO_IDX_LSB     2
`define TPIO_IDX_MSB     5
`define TPIO_HI_LSB      6
`define TPIO_HI_ZERO     6'h00
`define TPIO_ALIGN_ZERO  2'h0

// Reset values and masks.
`define TPIO_BYTE_ZERO   8'h00
`define TPIO_WORD_ZERO   32'h0000_0000
`define TPIO_C_ZERO      7'h00
`define TPIO_C_MASK      8'h7f
`define TPIO_RD_PAD      24'h00_0000
`define TPIO_C_PAD       1'h0
`define TPIO_ADCH_ONE    8'h01

`endif

// >>> rtl/tpio_ports.v
`include "tpio_consts.vh"
`timescale 1ns/1ps

// Three-stage pin synchroniser with an agreement filter.
// Only stage two reads stage one, so a metastable flop reaches no logic.
// A bit of the filtered level moves only once stages two and three agree on it.
module tpio_pin_sync #(
    parameter WIDTH = 8
) (
    pclk,
    presetn,
    ce,
    pin_async,
    level
);
    input  wire             pclk;       // Bus clock.
    input  wire             presetn;    // Asynchronous reset, active low.
    input  wire             ce;         // Clock enable; state freezes while low.
    input  wire [WIDTH-1:0] pin_async;  // Raw pin levels from outside the clock domain.
    output wire [WIDTH-1:0] level;      // Filtered, synchronised pin levels.

    reg [WIDTH-1:0] stage1_reg;         // First flop, read by the second only.
    reg [WIDTH-1:0] stage2_reg;         // Second flop.
    reg [WIDTH-1:0] stage3_reg;         // Third flop.
    reg [WIDTH-1:0] level_reg;          // Level accepted after agreement.
    wire [WIDTH-1:0] agree;             // Bits where stages two and three match.

    assign agree = ~(stage2_reg ^ stage3_reg);
    assign level = level_reg;

    // Shift chain and filter; reset loads constants only.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stage1_reg <= {WIDTH{1'b0}};
            stage2_reg <= {WIDTH{1'b0}};
            stage3_reg <= {WIDTH{1'b0}};
            level_reg  <= {WIDTH{1'b0}};
        end else if (ce) begin
            stage1_reg <= pin_async;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            // Agreeing bits take the new level, disagreeing bits hold.
            level_reg  <= (stage3_reg & agree) | (level_reg & ~agree);
        end
    end
endmodule // tpio_pin_sync

// Three parallel ports behind an APB slave.
// Port A and port B are eight bits wide, port C seven bits.
module tpio_ports (
    pclk,
    presetn,
    ce,
    psel,
    penable,
    pwrite,
    paddr,
    pwdata,
    prdata,
    pready,
    pslverr,
    port_a_in,
    port_a_out,
    port_a_oe,
    port_a_pullup,
    port_b_in,
    port_b_out,
    port_b_oe,
    port_c_in,
    port_c_out,
    port_c_oe,
    port_c_pullup,
    key_interrupt_enables,
    key_inputs,
    analog_select_enable,
    analog_channel_select,
    analog_channel_inputs
);
    input  wire                     pclk;                  // Bus clock, 125 MHz.
    input  wire                     presetn;               // Asynchronous reset, active low.
    input  wire                     ce;                    // Clock enable; all state freezes while low.
    input  wire                     psel;                  // APB select.
    input  wire                     penable;               // APB access phase.
    input  wire                     pwrite;                // APB direction, high for write.
    input  wire [`TPIO_ADDR_W-1:0]  paddr;                 // APB byte address.
    input  wire [`TPIO_DATA_W-1:0]  pwdata;                // APB write data.
    output wire [`TPIO_DATA_W-1:0]  prdata;                // APB read data.
    output wire                     pready;                // APB ready.
    output wire                     pslverr;               // APB error for unmapped addresses.
    input  wire [`TPIO_PORT_W-1:0]  port_a_in;             // Port A pin levels.
    output wire [`TPIO_PORT_W-1:0]  port_a_out;            // Port A output levels.
    output wire [`TPIO_PORT_W-1:0]  port_a_oe;             // Port A output enables, high drives.
    output wire [`TPIO_PORT_W-1:0]  port_a_pullup;         // Port A pullup enables.
    input  wire [`TPIO_PORT_W-1:0]  port_b_in;             // Port B pin levels.
    output wire [`TPIO_PORT_W-1:0]  port_b_out;            // Port B output levels.
    output wire [`TPIO_PORT_W-1:0]  port_b_oe;             // Port B output enables, high drives.
    input  wire [`TPIO_PORTC_W-1:0] port_c_in;             // Port C pin levels.
    output wire [`TPIO_PORTC_W-1:0] port_c_out;            // Port C output levels.
    output wire [`TPIO_PORTC_W-1:0] port_c_oe;             // Port C output enables, high drives.
    output wire [`TPIO_PORTC_W-1:0] port_c_pullup;         // Port C pullup enables.
    input  wire [`TPIO_PORT_W-1:0]  key_interrupt_enables; // Key module claims of port A pins.
    output wire [`TPIO_PORT_W-1:0]  key_inputs;            // Synchronised levels to the key module.
    input  wire                     analog_select_enable;  // Converter channel selection is active.
    input  wire [`TPIO_ADCH_W-1:0]  analog_channel_select; // Converter channel number.
    output wire [`TPIO_PORT_W-1:0]  analog_channel_inputs; // Port B pins handed to the converter.

    // Data latches carry no reset: their contents survive a system reset.
    reg [`TPIO_PORT_W-1:0]  lat_a_reg;       // Port A data latch.
    reg [`TPIO_PORT_W-1:0]  lat_b_reg;       // Port B data latch.
    reg [`TPIO_PORTC_W-1:0] lat_c_reg;       // Port C data latch.
    // Configuration registers with a defined reset value.
    reg [`TPIO_PORT_W-1:0]  dir_a_reg;       // Port A direction.
    reg [`TPIO_PORT_W-1:0]  dir_b_reg;       // Port B direction.
    reg [`TPIO_PORTC_W-1:0] dir_c_reg;       // Port C direction.
    reg [`TPIO_PORT_W-1:0]  pue_a_reg;       // Port A pullup enables.
    reg [`TPIO_PORTC_W-1:0] pue_c_reg;       // Port C pullup enables.
    // Registered pin controls, so that every output comes from a flop.
    reg [`TPIO_PORT_W-1:0]  oe_a_reg;        // Port A drive enables.
    reg [`TPIO_PORT_W-1:0]  oe_b_reg;        // Port B drive enables.
    reg [`TPIO_PORTC_W-1:0] oe_c_reg;        // Port C drive enables.
    reg [`TPIO_PORT_W-1:0]  pu_a_reg;        // Port A pullup control.
    reg [`TPIO_PORTC_W-1:0] pu_c_reg;        // Port C pullup control.
    reg [`TPIO_PORT_W-1:0]  key_reg;         // Key module inputs.
    reg [`TPIO_PORT_W-1:0]  analog_reg;      // Converter claim mask.
    // Bus answer registers.
    reg [`TPIO_DATA_W-1:0]  prdata_reg;      // Captured read data.
    reg                     pready_reg;      // Ready during the access phase.
    reg                     pslverr_reg;     // Error during the access phase.

    // Next values of the configuration registers.
    reg [`TPIO_PORT_W-1:0]  dir_a_next;      // Port A direction next.
    reg [`TPIO_PORT_W-1:0]  dir_b_next;      // Port B direction next.
    reg [`TPIO_PORTC_W-1:0] dir_c_next;      // Port C direction next.
    reg [`TPIO_PORT_W-1:0]  pue_a_next;      // Port A pullup enables next.
    reg [`TPIO_PORTC_W-1:0] pue_c_next;      // Port C pullup enables next.
    reg [`TPIO_PORT_W-1:0]  analog_next;     // Converter claim mask next.
    reg [`TPIO_DATA_W-1:0]  rd_word;         // Read mux result.

    wire [`TPIO_PORT_W-1:0]  lvl_a;          // Synchronised port A levels.
    wire [`TPIO_PORT_W-1:0]  lvl_b;          // Synchronised port B levels.
    wire [`TPIO_PORTC_W-1:0] lvl_c;          // Synchronised port C levels.
    wire [`TPIO_IDX_W-1:0]   idx;            // Register index from the address.
    wire                     addr_ok;        // Aligned and inside the small window.
    wire                     hit_a_data;     // Port A data selected.
    wire                     hit_b_data;     // Port B data selected.
    wire                     hit_c_data;     // Port C data selected.
    wire                     hit_a_dir;      // Port A direction selected.
    wire                     hit_b_dir;      // Port B direction selected.
    wire                     hit_c_dir;      // Port C direction selected.
    wire                     hit_a_pue;      // Port A pullup enables selected.
    wire                     hit_c_pue;      // Port C pullup enables selected.
    wire                     hit_any;        // Any register selected.
    wire                     setup;          // APB setup cycle.
    wire                     wr;             // Write completes at this edge.
    wire [`TPIO_PORT_W-1:0]  wbyte;          // Low byte of the write data.

    // Pin levels pass four flops before any register read sees them.
    tpio_pin_sync #(.WIDTH(`TPIO_PORT_W)) u_sync_a (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .pin_async (port_a_in),
        .level     (lvl_a)
    );

    tpio_pin_sync #(.WIDTH(`TPIO_PORT_W)) u_sync_b (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .pin_async (port_b_in),
        .level     (lvl_b)
    );

    tpio_pin_sync #(.WIDTH(`TPIO_PORTC_W)) u_sync_c (
        .pclk      (pclk),
        .presetn   (presetn),
        .ce        (ce),
        .pin_async (port_c_in),
        .level     (lvl_c)
    );

    // Address decode: one aligned word per register, everything else unmapped.
    assign idx        = paddr[`TPIO_IDX_MSB:`TPIO_IDX_LSB];
    assign addr_ok    = (paddr[`TPIO_IDX_LSB-1:0] == `TPIO_ALIGN_ZERO) &&
                        (paddr[`TPIO_ADDR_W-1:`TPIO_HI_LSB] == `TPIO_HI_ZERO);
    assign hit_a_data = addr_ok && (idx == `TPIO_IDX_A_DATA);
    assign hit_b_data = addr_ok && (idx == `TPIO_IDX_B_DATA);
    assign hit_c_data = addr_ok && (idx == `TPIO_IDX_C_DATA);
    assign hit_a_dir  = addr_ok && (idx == `TPIO_IDX_A_DIR);
    assign hit_b_dir  = addr_ok && (idx == `TPIO_IDX_B_DIR);
    assign hit_c_dir  = addr_ok && (idx == `TPIO_IDX_C_DIR);
    assign hit_a_pue  = addr_ok && (idx == `TPIO_IDX_A_PUE);
    assign hit_c_pue  = addr_ok && (idx == `TPIO_IDX_C_PUE);
    assign hit_any    = hit_a_data | hit_b_data | hit_c_data | hit_a_dir |
                        hit_b_dir | hit_c_dir | hit_a_pue | hit_c_pue;

    // The slave answers in the first access cycle, so the write lands there.
    assign setup = psel & ~penable;
    assign wr    = psel & penable & pwrite & pready_reg;
    assign wbyte = pwdata[`TPIO_PORT_W-1:0];

    // Next values; pin controls use them so that the pins move with the
    // register at the same edge.
    always @* begin
        dir_a_next = dir_a_reg;
        dir_b_next = dir_b_reg;
        dir_c_next = dir_c_reg;
        pue_a_next = pue_a_reg;
        pue_c_next = pue_c_reg;
        if (wr && hit_a_dir) begin
            dir_a_next = wbyte;
        end
        if (wr && hit_b_dir) begin
            dir_b_next = wbyte;
        end
        if (wr && hit_c_dir) begin
            // Bit seven has no flop, so its write data is dropped.
            dir_c_next = wbyte[`TPIO_PORTC_W-1:0];
        end
        if (wr && hit_a_pue) begin
            pue_a_next = wbyte;
        end
        if (wr && hit_c_pue) begin
            pue_c_next = wbyte[`TPIO_PORTC_W-1:0];
        end
    end

    // Converter claim: one port B pin when the channel lies on the port.
    always @* begin
        analog_next = `TPIO_BYTE_ZERO;
        if (analog_select_enable && (analog_channel_select < `TPIO_PORT_W)) begin
            analog_next = `TPIO_ADCH_ONE << analog_channel_select[2:0];
        end
    end

    // Read mux: output bits show the latch, input bits the synchronised pin.
    always @* begin
        rd_word = `TPIO_WORD_ZERO;
        if (hit_a_data) begin
            rd_word = {`TPIO_RD_PAD, (dir_a_reg & lat_a_reg) | (~dir_a_reg & lvl_a)};
        end else if (hit_b_data) begin
            // A converter pin has its digital input cut off and reads zero;
            // other pins read latch or pin as usual.
            rd_word = {`TPIO_RD_PAD,
                       ~analog_reg & ((dir_b_reg & lat_b_reg) | (~dir_b_reg & lvl_b))};
        end else if (hit_c_data) begin
            rd_word = {`TPIO_RD_PAD, `TPIO_C_PAD,
                       (dir_c_reg & lat_c_reg) | (~dir_c_reg & lvl_c)};
        end else if (hit_a_dir) begin
            rd_word = {`TPIO_RD_PAD, dir_a_reg};
        end else if (hit_b_dir) begin
            rd_word = {`TPIO_RD_PAD, dir_b_reg};
        end else if (hit_c_dir) begin
            rd_word = {`TPIO_RD_PAD, `TPIO_C_PAD, dir_c_reg};
        end else if (hit_a_pue) begin
            rd_word = {`TPIO_RD_PAD, pue_a_reg};
        end else if (hit_c_pue) begin
            rd_word = {`TPIO_RD_PAD, `TPIO_C_PAD, pue_c_reg};
        end
    end

    // Data latches: no reset branch, so a reset leaves them untouched.
    // A write lands whatever the direction; an input bit still reads its pin.
    always @(posedge pclk) begin
        if (ce) begin
            if (wr && hit_a_data) begin
                lat_a_reg <= wbyte;
            end
            if (wr && hit_b_data) begin
                lat_b_reg <= wbyte;
            end
            if (wr && hit_c_data) begin
                lat_c_reg <= wbyte[`TPIO_PORTC_W-1:0];
            end
        end
    end

    // Configuration and pin control flops.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_a_reg  <= `TPIO_BYTE_ZERO;
            dir_b_reg  <= `TPIO_BYTE_ZERO;
            dir_c_reg  <= `TPIO_C_ZERO;
            pue_a_reg  <= `TPIO_BYTE_ZERO;
            pue_c_reg  <= `TPIO_C_ZERO;
            oe_a_reg   <= `TPIO_BYTE_ZERO;
            oe_b_reg   <= `TPIO_BYTE_ZERO;
            oe_c_reg   <= `TPIO_C_ZERO;
            pu_a_reg   <= `TPIO_BYTE_ZERO;
            pu_c_reg   <= `TPIO_C_ZERO;
            key_reg    <= `TPIO_BYTE_ZERO;
            analog_reg <= `TPIO_BYTE_ZERO;
        end else if (ce) begin
            dir_a_reg  <= dir_a_next;
            dir_b_reg  <= dir_b_next;
            dir_c_reg  <= dir_c_next;
            pue_a_reg  <= pue_a_next;
            pue_c_reg  <= pue_c_next;
            // A key-claimed pin is held as an input for the key module.
            oe_a_reg   <= dir_a_next & ~key_interrupt_enables;
            // The converter channel overrides the port B direction.
            oe_b_reg   <= dir_b_next & ~analog_next;
            oe_c_reg   <= dir_c_next;
            // Pullup only on an input with its enable set; output kills it.
            pu_a_reg   <= pue_a_next & ~dir_a_next;
            pu_c_reg   <= pue_c_next & ~dir_c_next;
            // Claimed pins forward their synchronised level to the key module.
            key_reg    <= lvl_a & key_interrupt_enables;
            analog_reg <= analog_next;
        end
    end

    // APB answer: captured in the setup cycle, shown in the access cycle.
    // Zero wait states keep the slave simple; the pin sample is one cycle old.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_reg  <= `TPIO_WORD_ZERO;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else if (ce) begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~hit_any;
            if (setup && !pwrite) begin
                prdata_reg <= rd_word;
            end else if (setup) begin
                prdata_reg <= `TPIO_WORD_ZERO;
            end
        end
    end

    // Every output is a flop.
    assign prdata                = prdata_reg;
    assign pready                = pready_reg;
    assign pslverr               = pslverr_reg;
    assign port_a_out            = lat_a_reg;
    assign port_a_oe             = oe_a_reg;
    assign port_a_pullup         = pu_a_reg;
    assign port_b_out            = lat_b_reg;
    assign port_b_oe             = oe_b_reg;
    assign port_c_out            = lat_c_reg;
    assign port_c_oe             = oe_c_reg;
    assign port_c_pullup         = pu_c_reg;
    assign key_inputs            = key_reg;
    assign analog_channel_inputs = analog_reg;
endmodule // tpio_ports

// >>> verif/tpio_board.sv
`timescale 1ns/1ps
// Board on one port: driver, pullup or float.
module tpio_board #(
    parameter W = 8
) (
    input  wire         pclk,
    input  wire [W-1:0] out,
    input  wire [W-1:0] oe,
    input  wire [W-1:0] pu,
    input  wire [W-1:0] ext,
    input  wire [W-1:0] ext_en,
    output wire [W-1:0] pin
);
    reg [W-1:0] float_reg = {W{1'b0}}; // A floating line toggles; no stale level.
    // Toggle each cycle.
    always @(posedge pclk) begin
        float_reg <= ~float_reg;
    end
    // Block first, then board, then pullup.
    assign pin = (oe & out) | (~oe & ext_en & ext) | (~oe & ~ext_en & pu)
               | (~oe & ~ext_en & ~pu & float_reg);
endmodule // tpio_board

// >>> verif/tpio_ports_properties.sv
`timescale 1ns/1ps
`include "tpio_consts.vh"
// Bus and pin-control checks.
module tpio_ports_chk (
    input wire                     pclk,
    input wire                     presetn,
    input wire                     ce,
    input wire                     psel,
    input wire                     penable,
    input wire                     pwrite,
    input wire [`TPIO_ADDR_W-1:0]  paddr,
    input wire [`TPIO_DATA_W-1:0]  pwdata,
    input wire [`TPIO_DATA_W-1:0]  prdata,
    input wire                     pready,
    input wire                     pslverr,
    input wire [`TPIO_PORT_W-1:0]  port_a_out,
    input wire [`TPIO_PORT_W-1:0]  port_a_oe,
    input wire [`TPIO_PORT_W-1:0]  port_a_pullup,
    input wire [`TPIO_PORT_W-1:0]  port_b_oe,
    input wire [`TPIO_PORTC_W-1:0] port_c_oe,
    input wire [`TPIO_PORTC_W-1:0] port_c_pullup,
    input wire [`TPIO_PORT_W-1:0]  key_interrupt_enables,
    input wire                     analog_select_enable,
    input wire [`TPIO_ADCH_W-1:0]  analog_channel_select,
    input wire [`TPIO_PORT_W-1:0]  analog_channel_inputs
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // APB phases.
    sequence s_setup;
        psel && !penable && ce;
    endsequence
    sequence s_access;
        psel && penable && ce;
    endsequence
    AST_READY_AFTER_SETUP: assert property (s_setup ##1 s_access |-> pready)
        else $error("no pready");
    AST_READY_PULSE: assert property (pready |=> !pready)
        else $error("pready too long");
    AST_ERR_WITH_READY: assert property (pslverr |-> pready)
        else $error("lone pslverr");
    AST_RESET_INPUTS: assert property ($rose(presetn)
        |-> !(|{port_a_oe, port_b_oe, port_c_oe})) else $error("driven after reset");
    AST_PULLUP_OFF_OUT: assert property (!(|{port_a_pullup & port_a_oe,
        port_c_pullup & port_c_oe})) else $error("pullup on output");
    AST_LATCH_WRITE: assert property (s_access ##0 (pready && pwrite && paddr == 12'h000)
        |=> port_a_out == $past(pwdata[7:0])) else $error("port A latch");
    AST_DIR_DRIVES_OE: assert property (s_access ##0 (pready && pwrite && paddr == 12'h014
        && !analog_select_enable && analog_channel_inputs == 8'h00)
        |=> port_b_oe == $past(pwdata[7:0])) else $error("port B oe wrong");
    AST_ANALOG_OWNS: assert property (!(|(port_b_oe & analog_channel_inputs)))
        else $error("analog pin driven");
    AST_ANALOG_MASK: assert property (analog_select_enable && analog_channel_select < 5'd8
        |=> analog_channel_inputs == (`TPIO_ADCH_ONE << $past(analog_channel_select)))
        else $error("analog mask");
    AST_ANALOG_NONE: assert property (!analog_select_enable || analog_channel_select > 5'd7
        |=> analog_channel_inputs == 8'h00) else $error("stray analog mask");
    AST_KEY_OE: assert property (!(|(port_a_oe & $past(key_interrupt_enables))))
        else $error("key pin driven");
    AST_C_BIT7: assert property (pready && !pwrite && (paddr == 12'h008 || paddr == 12'h018)
        |-> prdata[31:7] == 25'h0) else $error("port C bit 7");
endmodule // tpio_ports_chk

bind tpio_ports tpio_ports_chk i_tpio_ports_chk (.*);

// >>> verif/tpio_ports_test.sv
`timescale 1ns/1ps
`include "tpio_consts.vh"
// Bench for the port block.
module tpio_ports_test;
    reg         pclk, presetn, ce, psel, penable, pwrite, rerr, ase;
    reg  [11:0] paddr;
    reg  [31:0] pwdata, rd;
    reg  [7:0]  ext [0:2];
    reg  [7:0]  en [0:2];
    reg  [7:0]  kie;
    reg  [4:0]  ach;
    wire [31:0] prdata;
    wire        pready, pslverr;
    wire [7:0]  a_in, a_out, a_oe, a_pu, b_in, b_out, b_oe, kin, amask;
    wire [6:0]  c_in, c_out, c_oe, c_pu;
    wire [23:0] oe_all  = {1'b0, c_oe, b_oe, a_oe};
    wire [23:0] out_all = {1'b0, c_out, b_out, a_out};
    integer     fail_count, cmp_count, cyc, i;

    tpio_ports i_tpio_ports (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .port_a_in(a_in), .port_a_out(a_out),
        .port_a_oe(a_oe), .port_a_pullup(a_pu), .port_b_in(b_in), .port_b_out(b_out),
        .port_b_oe(b_oe), .port_c_in(c_in), .port_c_out(c_out), .port_c_oe(c_oe),
        .port_c_pullup(c_pu), .key_interrupt_enables(kie), .key_inputs(kin),
        .analog_select_enable(ase), .analog_channel_select(ach),
        .analog_channel_inputs(amask));
    tpio_board #(.W(8)) i_tpio_board_a (.pclk(pclk), .out(a_out), .oe(a_oe), .pu(a_pu),
        .ext(ext[0]), .ext_en(en[0]), .pin(a_in));
    tpio_board #(.W(8)) i_tpio_board_b (.pclk(pclk), .out(b_out), .oe(b_oe), .pu(8'h00),
        .ext(ext[1]), .ext_en(en[1]), .pin(b_in));
    tpio_board #(.W(7)) i_tpio_board_c (.pclk(pclk), .out(c_out), .oe(c_oe), .pu(c_pu),
        .ext(ext[2][6:0]), .ext_en(en[2][6:0]), .pin(c_in));

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    // Cycle ceiling; a hang fails.
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count = fail_count + 1;
            final_report;
        end
    end
    task check(input [31:0] exp, input [31:0] got, input string nm);
        begin
            cmp_count = cmp_count + 1;
            if (got !== exp) begin
                fail_count = fail_count + 1;
                $display("CHECK FAILED %0s expected %h seen %h", nm, exp, got);
            end
        end
    endtask
    // One APB transfer, then one idle cycle.
    task apb(input wr_i, input [11:0] ad, input [31:0] wd);
        begin
            psel    <= 1'b1;
            pwrite  <= wr_i;
            paddr   <= ad;
            pwdata  <= wd;
            @(posedge pclk);
            penable <= 1'b1;
            @(posedge pclk);
            while (pready !== 1'b1)
                @(posedge pclk);
            rd   = prdata;
            rerr = pslverr;
            psel    <= 1'b0;
            penable <= 1'b0;
            @(posedge pclk);
        end
    endtask
    task rdchk(input [11:0] ad, input [31:0] exp, input string nm);
        begin
            apb(1'b0, ad, 32'h0);
            check(exp, rd, nm);
        end
    endtask
    // Reads, directions and latches of one port.
    task t_port(input integer p);
        reg [7:0]  m;
        reg [11:0] da;
        begin
            m = (p == 2) ? 8'h7f : 8'hff;
            da = p * 4;
            en[p]  <= 8'hff;
            ext[p] <= 8'h3c;
            apb(1'b1, da, 32'hffff_ffa5);
            repeat (8) @(posedge pclk);
            rdchk(da, 8'h3c & m, "pin read");
            en[p] <= 8'h0f;
            apb(1'b1, da + 12'h10, 32'hf0);
            check(8'hf0 & m, oe_all[p*8 +: 8], "oe");
            check(8'ha5 & m, out_all[p*8 +: 8], "latch out");
            repeat (8) @(posedge pclk);
            rdchk(da, 8'hac & m, "mixed read");
            apb(1'b1, da, 32'h5a);
            rdchk(da, 8'h5c & m, "rewrite read");
            rdchk(da + 12'h10, 8'hf0 & m, "dir read");
        end
    endtask
    // Pullups follow enable and input direction.
    task t_pullup;
        begin
            en[0] <= 8'h00;
            apb(1'b1, 12'h034, 32'hff);
            check(8'h0f, a_pu, "pullup a");
            repeat (8) @(posedge pclk);
            rdchk(12'h000, 8'h5f, "pulled read");
            apb(1'b1, 12'h010, 32'hff);
            check(8'h00, a_pu, "pullup off");
            apb(1'b1, 12'h034, 32'h00);
            apb(1'b1, 12'h010, 32'h00);
            check(8'h00, a_pu, "pullup disabled");
            apb(1'b1, 12'h038, 32'hff);
            check(7'h0f, c_pu, "pullup c");
        end
    endtask
    // Each channel claims its port B pin.
    task t_analog;
        begin
            en[1] <= 8'h00;
            apb(1'b1, 12'h014, 32'hff);
            ase <= 1'b1;
            for (i = 0; i < 8; i = i + 1) begin
                ach <= i;
                repeat (2) @(posedge pclk);
                check(8'h01 << i, amask, "channel mask");
                check(8'hff ^ (8'h01 << i), b_oe, "channel oe");
            end
            ach <= 5'd9;
            repeat (2) @(posedge pclk);
            check(8'hff, b_oe, "no channel oe");
            ase <= 1'b0;
        end
    endtask
    // A key pin stops driving, passes its level.
    task t_key;
        begin
            apb(1'b1, 12'h010, 32'hff);
            kie    <= 8'h01;
            en[0]  <= 8'h01;
            ext[0] <= 8'h01;
            repeat (8) @(posedge pclk);
            check(8'hfe, a_oe, "key oe");
            check(1'b1, kin[0], "key high");
            ext[0] <= 8'h00;
            repeat (8) @(posedge pclk);
            check(1'b0, kin[0], "key low");
            kie <= 8'h00;
        end
    endtask
    // Unmapped: error, zero data.
    task t_unmapped;
        begin
            apb(1'b0, 12'h00c, 32'h0);
            check(32'h0, rd, "unmapped data");
            check(1'b1, rerr, "unmapped err");
            apb(1'b1, 12'h001, 32'hff);
            check(1'b1, rerr, "unaligned write");
        end
    endtask
    // Mid-run reset: directions clear, latches stay.
    task t_reset_keep;
        begin
            presetn <= 1'b0;
            repeat (3) @(posedge pclk);
            presetn <= 1'b1;
            @(posedge pclk);
            check(24'h0, oe_all, "oe after reset");
            check(24'h5a5a5a, out_all, "latches kept");
            rdchk(12'h014, 32'h0, "dir b reset");
        end
    endtask
    task final_report;
        begin
            $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
            if (fail_count == 0 && cmp_count > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    initial begin
        fail_count = 0;
        cmp_count = 0;
        cyc = 0;
        ce = 1'b1;
        presetn = 1'b0;
        {psel, penable, pwrite, ase, rerr} = 5'h00;
        {paddr, pwdata, rd, kie, ach, ext[0], ext[1], ext[2], en[0], en[1], en[2]} = 0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk(12'h010, 32'h0, "dir a reset");
        rdchk(12'h018, 32'h0, "dir c reset");
        check(24'h0, oe_all, "oe at start");
        for (i = 0; i < 3; i = i + 1)
            t_port(i);
        t_pullup;
        t_analog;
        t_key;
        t_unmapped;
        t_reset_keep;
        final_report;
    end
endmodule // tpio_ports_test
